//--- rtl/tws_cfg.svh
// Purpose: Constants of the two-wire memory slave front end.
// Assumes: A 125 MHz system clock.
// Notes:   Included by the package and by every design module.
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH

// ------------------------------------------------------------------
// Geometry
// ------------------------------------------------------------------
`define TWS_ADDR_W     7
`define TWS_DATA_W     8
`define TWS_MEM_DEPTH  128
`define TWS_PAGE_W     2
`define TWS_FIFO_DEPTH 32

// ------------------------------------------------------------------
// Bit framing
// ------------------------------------------------------------------
`define TWS_BITS_FULL  4'h8
`define TWS_BIT_LAST   4'h7
`define TWS_BIT_ZERO   4'h0

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define TWS_PIN_RST    3'h3
`define TWS_SDA_REL    1'h1
`define TWS_RST_SYNC   2'h0

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define TWS_CLK_MHZ    125
`define TWS_PROG_US    5000

`endif

//--- rtl/tws_fifo.sv
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Read data is shown combinationally while valid is high.
`timescale 1ns/100ps
`include "tws_cfg.svh"

module tws_fifo #(
  parameter int WIDTH = `TWS_ADDR_W + `TWS_DATA_W,
  parameter int DEPTH = `TWS_FIFO_DEPTH
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             wr_valid_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  wr_ready_out,
  output logic                  rd_valid_out,
  output logic      [WIDTH-1:0] rd_data_out,
  input  wire logic             rd_ready_in
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    nxt_wr_ptr;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW-1:0]    nxt_rd_ptr;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      nxt_cnt;
  logic             do_wr;
  logic             do_rd;

  // ----------------------------------------------------------------
  // Handshake and next state
  // ----------------------------------------------------------------
  always_comb begin
    wr_ready_out = (cnt_ff != (AW+1)'(DEPTH));
    rd_valid_out = (cnt_ff != '0);
    rd_data_out  = store[rd_ptr_ff];
    do_wr        = wr_valid_in && wr_ready_out;
    do_rd        = rd_ready_in && rd_valid_out;
    nxt_wr_ptr   = do_wr ? wr_ptr_ff + AW'(1) : wr_ptr_ff;
    nxt_rd_ptr   = do_rd ? rd_ptr_ff + AW'(1) : rd_ptr_ff;
    nxt_cnt      = cnt_ff;
    if (do_wr && !do_rd) begin
      nxt_cnt = cnt_ff + (AW+1)'(1);
    end else if (do_rd && !do_wr) begin
      nxt_cnt = cnt_ff - (AW+1)'(1);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff    <= nxt_cnt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      store[wr_ptr_ff] <= wr_data_in;
    end
  end

endmodule : tws_fifo

//--- rtl/tws_pkg.sv
// Purpose: Types shared by the two-wire memory slave front end.
// Assumes: The constants header is on the include path.
// Notes:   Holds types only; numbers live in the header.
`include "tws_cfg.svh"

package tws_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [`TWS_ADDR_W-1:0] tws_addr_t;
  typedef logic [`TWS_DATA_W-1:0] tws_byte_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CMD,
    ST_CMD_ACK,
    ST_WR,
    ST_WR_ACK,
    ST_RD,
    ST_RD_ACK,
    ST_COMMIT,
    ST_FLUSH,
    ST_PROG
  } tws_state_t;

endpackage : tws_pkg

//--- rtl/tws_top.sv
// Purpose: Slave front end of a 128-byte two-wire serial memory.
// Assumes: The bus master drives the serial clock; pins are asynchronous.
// Notes:   Summary of operation below; nrst_in is the power-on reset.
//
// Summary of operation
// - Data falling while clock high is a start condition.
// - Outside programming, wait for start; ignore bus while programming.
// - Data rising while clock high is a stop; it ends communication.
// - A stop after a read returns the device to standby.
// - A stop after a write with write protect low starts the self-timed programming cycle.
// - Transmitter releases data after 8 bits; receiver acknowledges in 9th.
// - Each received write byte is acknowledged low in the 9th bit while the 32-entry buffer has room.
// - Incoming data is sampled on each rising serial clock edge.
// - Write protect high blocks all memory changes; low allows them.
// - While power-on reset is active no command is answered.
// - The data line is open drain: pulled low or released.
// - The device is slave only and never drives the clock.
// - Address and direction share one command byte.
// - The array holds 128 locations of 8 bits.
// - Page writes take up to 32 bytes; address advances per byte and wraps within a 4-byte page.
`timescale 1ns/100ps
`include "tws_cfg.svh"

module tws_top
  import tws_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `TWS_PROG_US * `TWS_CLK_MHZ,
  parameter int          FIFO_DEPTH  = `TWS_FIFO_DEPTH,
  parameter int          MEM_DEPTH   = `TWS_MEM_DEPTH
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic write_protect_input_in,
  output logic      sda_out,
  output logic      sda_oe_n_out,
  output logic      busy_out
);

  localparam int CNT_W  = $clog2(PROG_CYCLES + 1);
  localparam int FIFO_W = `TWS_ADDR_W + `TWS_DATA_W;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]       rst_sync_ff;
  logic [1:0]       nxt_rst_sync;
  logic             rst_n;
  logic [2:0]       pin_raw;
  logic [2:0]       pin_s1_ff;
  logic [2:0]       pin_s2_ff;
  logic [2:0]       pin_s3_ff;
  logic [2:0]       pin_st_ff;
  logic [2:0]       nxt_pin_st;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_cond;
  logic             stop_cond;
  logic             sda_now;
  logic             wp_now;
  tws_state_t       state_ff;
  tws_state_t       nxt_state;
  logic [3:0]       bit_cnt_ff;
  logic [3:0]       nxt_bit_cnt;
  tws_byte_t        shift_ff;
  tws_byte_t        nxt_shift;
  tws_addr_t        addr_ff;
  tws_addr_t        nxt_addr;
  logic             rw_ff;
  logic             nxt_rw;
  logic             wrote_ff;
  logic             nxt_wrote;
  logic             sda_oe_n_ff;
  logic             nxt_sda_oe_n;
  logic             busy_ff;
  logic             nxt_busy;
  logic [CNT_W-1:0] prog_cnt_ff;
  logic [CNT_W-1:0] nxt_prog_cnt;
  logic             push_c;
  logic             pop_c;
  logic             mem_we_c;
  logic             fifo_wr_ready;
  logic             fifo_rd_valid;
  logic [FIFO_W-1:0] fifo_rd_data;
  tws_byte_t        mem_rd;
  tws_byte_t        mem [MEM_DEPTH];

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic tws_addr_t page_next(input tws_addr_t a);
    page_next = {a[`TWS_ADDR_W-1:`TWS_PAGE_W],
                 a[`TWS_PAGE_W-1:0] + `TWS_PAGE_W'(1)};
  endfunction : page_next

  function automatic logic is_busy(input tws_state_t st);
    is_busy = (st == ST_COMMIT) || (st == ST_FLUSH) || (st == ST_PROG);
  endfunction : is_busy

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  assign nxt_rst_sync = {rst_sync_ff[0], 1'b1};
  assign rst_n        = rst_sync_ff[1];

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_ff <= `TWS_RST_SYNC;
    end else begin
      rst_sync_ff <= nxt_rst_sync;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign pin_raw = {write_protect_input_in, sda_in, scl_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      assign nxt_pin_st[gi] = (pin_s2_ff[gi] == pin_s3_ff[gi]) ?
                              pin_s3_ff[gi] : pin_st_ff[gi];
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= `TWS_PIN_RST;
      pin_s2_ff <= `TWS_PIN_RST;
      pin_s3_ff <= `TWS_PIN_RST;
      pin_st_ff <= `TWS_PIN_RST;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_st_ff <= nxt_pin_st;
    end
  end

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  always_comb begin
    sda_now    = pin_st_ff[1];
    wp_now     = pin_st_ff[2];
    scl_rise   = !pin_st_ff[0] && nxt_pin_st[0];
    scl_fall   = pin_st_ff[0] && !nxt_pin_st[0];
    start_cond = pin_st_ff[0] && nxt_pin_st[0] &&
                 pin_st_ff[1] && !nxt_pin_st[1];
    stop_cond  = pin_st_ff[0] && nxt_pin_st[0] &&
                 !pin_st_ff[1] && nxt_pin_st[1];
  end

  // ----------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------
  assign mem_rd = mem[addr_ff];

  always_ff @(posedge clk_in) begin
    if (mem_we_c) begin
      mem[fifo_rd_data[FIFO_W-1:`TWS_DATA_W]] <=
        fifo_rd_data[`TWS_DATA_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Write data buffer
  // ----------------------------------------------------------------
  tws_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n),
    .wr_valid_in  (push_c),
    .wr_data_in   ({addr_ff, shift_ff}),
    .wr_ready_out (fifo_wr_ready),
    .rd_valid_out (fifo_rd_valid),
    .rd_data_out  (fifo_rd_data),
    .rd_ready_in  (pop_c)
  );

  // ----------------------------------------------------------------
  // Protocol next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state    = state_ff;
    nxt_bit_cnt  = bit_cnt_ff;
    nxt_shift    = shift_ff;
    nxt_addr     = addr_ff;
    nxt_rw       = rw_ff;
    nxt_wrote    = wrote_ff;
    nxt_sda_oe_n = sda_oe_n_ff;
    nxt_prog_cnt = prog_cnt_ff;
    push_c       = 1'b0;
    pop_c        = 1'b0;
    mem_we_c     = 1'b0;
    case (state_ff)
      ST_COMMIT: begin
        if (fifo_rd_valid) begin
          mem_we_c = 1'b1;
          pop_c    = 1'b1;
        end else begin
          nxt_state    = ST_PROG;
          nxt_prog_cnt = '0;
        end
      end
      ST_PROG: begin
        if (prog_cnt_ff == CNT_W'(PROG_CYCLES - 1)) begin
          nxt_state = ST_IDLE;
          nxt_wrote = 1'b0;
        end else begin
          nxt_prog_cnt = prog_cnt_ff + CNT_W'(1);
        end
      end
      ST_FLUSH: begin
        if (fifo_rd_valid) begin
          pop_c = 1'b1;
        end else begin
          nxt_state = ST_IDLE;
          nxt_wrote = 1'b0;
        end
      end
      default: begin
        if (stop_cond) begin
          nxt_sda_oe_n = `TWS_SDA_REL;
          if (!wrote_ff) begin
            nxt_state = ST_IDLE;
          end else if (wp_now) begin
            nxt_state = ST_FLUSH;
          end else begin
            nxt_state = ST_COMMIT;
          end
        end else if (start_cond) begin
          nxt_state    = ST_CMD;
          nxt_bit_cnt  = `TWS_BIT_ZERO;
          nxt_sda_oe_n = `TWS_SDA_REL;
        end else begin
          case (state_ff)
            ST_CMD: begin
              if (scl_rise) begin
                nxt_shift   = {shift_ff[6:0], sda_now};
                nxt_bit_cnt = bit_cnt_ff + 4'h1;
              end else if (scl_fall && bit_cnt_ff == `TWS_BITS_FULL) begin
                nxt_addr     = shift_ff[7:1];
                nxt_rw       = shift_ff[0];
                nxt_sda_oe_n = 1'b0;
                nxt_state    = ST_CMD_ACK;
              end
            end
            ST_CMD_ACK: begin
              if (scl_fall) begin
                nxt_bit_cnt = `TWS_BIT_ZERO;
                if (rw_ff) begin
                  nxt_state    = ST_RD;
                  nxt_shift    = mem_rd;
                  nxt_sda_oe_n = mem_rd[7];
                end else begin
                  nxt_state    = ST_WR;
                  nxt_sda_oe_n = `TWS_SDA_REL;
                end
              end
            end
            ST_WR: begin
              if (scl_rise) begin
                nxt_shift   = {shift_ff[6:0], sda_now};
                nxt_bit_cnt = bit_cnt_ff + 4'h1;
              end else if (scl_fall && bit_cnt_ff == `TWS_BITS_FULL) begin
                if (fifo_wr_ready) begin
                  push_c       = 1'b1;
                  nxt_wrote    = 1'b1;
                  nxt_sda_oe_n = 1'b0;
                  nxt_state    = ST_WR_ACK;
                end else begin
                  nxt_state = ST_IDLE;
                end
              end
            end
            ST_WR_ACK: begin
              if (scl_fall) begin
                nxt_sda_oe_n = `TWS_SDA_REL;
                nxt_bit_cnt  = `TWS_BIT_ZERO;
                nxt_addr     = page_next(addr_ff);
                nxt_state    = ST_WR;
              end
            end
            ST_RD: begin
              if (scl_fall) begin
                if (bit_cnt_ff == `TWS_BIT_LAST) begin
                  nxt_sda_oe_n = `TWS_SDA_REL;
                  nxt_bit_cnt  = `TWS_BIT_ZERO;
                  nxt_state    = ST_RD_ACK;
                end else begin
                  nxt_shift    = {shift_ff[6:0], 1'b0};
                  nxt_sda_oe_n = shift_ff[6];
                  nxt_bit_cnt  = bit_cnt_ff + 4'h1;
                end
              end
            end
            ST_RD_ACK: begin
              if (scl_rise) begin
                if (sda_now) begin
                  nxt_state = ST_IDLE;
                end else begin
                  nxt_addr = addr_ff + 7'h01;
                end
              end else if (scl_fall) begin
                nxt_state    = ST_RD;
                nxt_shift    = mem_rd;
                nxt_sda_oe_n = mem_rd[7];
                nxt_bit_cnt  = `TWS_BIT_ZERO;
              end
            end
            default: begin
              nxt_state = state_ff;
            end
          endcase
        end
      end
    endcase
    nxt_busy = is_busy(nxt_state);
  end

  // ----------------------------------------------------------------
  // Protocol registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= ST_IDLE;
      bit_cnt_ff  <= `TWS_BIT_ZERO;
      shift_ff    <= '0;
      addr_ff     <= '0;
      rw_ff       <= 1'b0;
      wrote_ff    <= 1'b0;
      sda_oe_n_ff <= `TWS_SDA_REL;
      busy_ff     <= 1'b0;
      prog_cnt_ff <= '0;
    end else begin
      state_ff    <= nxt_state;
      bit_cnt_ff  <= nxt_bit_cnt;
      shift_ff    <= nxt_shift;
      addr_ff     <= nxt_addr;
      rw_ff       <= nxt_rw;
      wrote_ff    <= nxt_wrote;
      sda_oe_n_ff <= nxt_sda_oe_n;
      busy_ff     <= nxt_busy;
      prog_cnt_ff <= nxt_prog_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The serial clock is an input only; the device never drives it.
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = sda_oe_n_ff;
  assign busy_out     = busy_ff;

endmodule : tws_top

//--- verification/tws_master.sv
// Purpose: Behavioural two-wire bus master driving the serial clock.
// Assumes: Outputs change at the falling system clock edge.
// Notes:   Clock stands high between frames; the bench resolves data.
`timescale 1ns/100ps
module tws_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_rel_out
);
  initial begin
    scl_out     = 1'b1;
    sda_rel_out = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask : wt
  task automatic bus_start();
    sda_rel_out = 1'b1;
    wt(5);
    scl_out = 1'b1;
    wt(10);
    sda_rel_out = 1'b0;
    wt(10);
    scl_out = 1'b0;
    wt(5);
  endtask : bus_start
  task automatic bus_stop();
    sda_rel_out = 1'b0;
    wt(5);
    scl_out = 1'b1;
    wt(10);
    sda_rel_out = 1'b1;
    wt(10);
  endtask : bus_stop
  task automatic bit_io(input logic b, output logic r);
    sda_rel_out = b;
    wt(5);
    scl_out = 1'b1;
    wt(5);
    r = sda_in;
    wt(5);
    scl_out = 1'b0;
    wt(5);
  endtask : bit_io
  task automatic wr8(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr8
  task automatic rd8(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~mack, r);
  endtask : rd8
endmodule : tws_master

//--- verification/tws_top_assertions.sv
// Purpose: Port-level checks of the two-wire memory front end.
// Assumes: PROG_CYCLES equals the value of the bound instance.
// Notes:   Bound to every tws_top instance below.
`timescale 1ns/100ps
module tws_top_assertions #(
  parameter int unsigned PROG_CYCLES = 50
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic write_protect_input_in,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic busy_out
);
  // ----------------------------------------------------------------
  // Busy length counter
  // ----------------------------------------------------------------
  logic [31:0] busy_cnt_ff;
  logic [31:0] nxt_busy_cnt;
  always_comb begin
    nxt_busy_cnt = busy_out ? busy_cnt_ff + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_cnt_ff <= 32'h0;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_sda_zero;
    sda_out == 1'b0;
  endproperty
  a_sda_zero: assert property (p_sda_zero)
    else $error("data output not low");
  property p_quiet_rst;
    $rose(nrst_in) |-> (sda_oe_n_out && !busy_out) [*8];
  endproperty
  a_quiet_rst: assert property (p_quiet_rst)
    else $error("activity right after reset");
  property p_chg_scl_low;
    $changed(sda_oe_n_out) |-> !$past(scl_in, 1) && !$past(scl_in, 3);
  endproperty
  a_chg_scl_low: assert property (p_chg_scl_low)
    else $error("data enable moved outside clock low");
  property p_busy_quiet;
    busy_out |-> sda_oe_n_out;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("data driven while busy");
  property p_busy_stop;
    $rose(busy_out) |-> $past(scl_in, 1) && $past(scl_in, 4);
  endproperty
  a_busy_stop: assert property (p_busy_stop)
    else $error("busy rose without stop");
  property p_prog_len;
    $fell(busy_out) && !write_protect_input_in |->
      busy_cnt_ff >= PROG_CYCLES && busy_cnt_ff <= PROG_CYCLES + 40;
  endproperty
  a_prog_len: assert property (p_prog_len)
    else $error("programming length wrong");
  property p_wp_no_prog;
    $fell(busy_out) && write_protect_input_in |-> busy_cnt_ff < PROG_CYCLES;
  endproperty
  a_wp_no_prog: assert property (p_wp_no_prog)
    else $error("programming while protected");
  property p_low_stands;
    $fell(sda_oe_n_out) |-> !sda_oe_n_out [*5];
  endproperty
  a_low_stands: assert property (p_low_stands)
    else $error("low drive too short");
endmodule : tws_top_assertions

bind tws_top tws_top_assertions #(
  .PROG_CYCLES(PROG_CYCLES)
) tws_top_assertions_inst (
  .clk_in(clk_in),
  .nrst_in(nrst_in),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .write_protect_input_in(write_protect_input_in),
  .sda_out(sda_out),
  .sda_oe_n_out(sda_oe_n_out),
  .busy_out(busy_out)
);

//--- verification/tws_top_tb_top.sv
// Purpose: Self-checking bench of the two-wire memory front end.
// Assumes: A shortened programming time of PROG cycles.
// Notes:   Memory contents are modelled in an integer array.
`timescale 1ns/100ps
module tws_top_tb_top;
  import tws_pkg::*;
  localparam int unsigned PROG = 400;
  logic        clk;
  logic        nrst;
  logic        wp;
  logic        scl;
  logic        rel;
  logic        sda;
  logic        sda_o;
  logic        oe_n;
  logic        busy;
  logic [31:0] seed = 32'h11;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          mem [128];
  assign sda = rel & (oe_n | sda_o);
  tws_top #(.PROG_CYCLES(PROG), .FIFO_DEPTH(32), .MEM_DEPTH(128))
    tws_top_inst (.clk_in(clk), .nrst_in(nrst), .scl_in(scl),
    .sda_in(sda), .write_protect_input_in(wp), .sda_out(sda_o),
    .sda_oe_n_out(oe_n), .busy_out(busy));
  tws_master tws_master_inst (.clk_in(clk), .sda_in(sda),
    .scl_out(scl), .sda_rel_out(rel));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_byte(input tws_byte_t got, input tws_byte_t exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic cmd(input tws_addr_t a, input logic rw, output logic ack);
    tws_master_inst.bus_start();
    tws_master_inst.wr8({a, rw}, ack);
  endtask : cmd
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk_bit(busy, 1'b0);
  endtask : wait_idle
  task automatic rd_chk(input int a, input int n);
    logic      ack;
    tws_byte_t d;
    cmd(tws_addr_t'(a), 1'b1, ack);
    chk_bit(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      tws_master_inst.rd8(i < n - 1, d);
      chk_byte(d, tws_byte_t'(mem[(a + i) % 128]));
    end
    tws_master_inst.bus_stop();
    repeat (20) @(negedge clk);
    chk_bit(busy, 1'b0);
  endtask : rd_chk
  task automatic print_verdict();
    $display("Compares %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic      ack;
    tws_byte_t d;
    nrst = 1'b0;
    wp   = 1'b0;
    foreach (mem[i]) mem[i] = -1;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (10) @(negedge clk);
    d = tws_byte_t'(xs());
    cmd(7'h00, 1'b0, ack);
    chk_bit(ack, 1'b1);
    tws_master_inst.wr8(d, ack);
    chk_bit(ack, 1'b1);
    tws_master_inst.bus_stop();
    mem[0] = int'(d);
    repeat (2) @(negedge clk);
    chk_bit(busy, 1'b1);
    cmd(7'h00, 1'b1, ack);
    chk_bit(ack, 1'b0);
    tws_master_inst.bus_stop();
    wait_idle();
    $display("Test byte write done");
    cmd(7'h7d, 1'b0, ack);
    chk_bit(ack, 1'b1);
    for (int i = 0; i < 33; i++) begin
      d = tws_byte_t'(xs());
      tws_master_inst.wr8(d, ack);
      chk_bit(ack, logic'(i < 32));
      if (i < 32) mem[124 + ((i + 1) % 4)] = int'(d);
    end
    tws_master_inst.bus_stop();
    wait_idle();
    rd_chk(124, 4);
    rd_chk(127, 2);
    $display("Test page write done");
    wp = 1'b1;
    repeat (10) @(negedge clk);
    cmd(7'h00, 1'b0, ack);
    tws_master_inst.wr8(~tws_byte_t'(mem[0]), ack);
    tws_master_inst.bus_stop();
    wait_idle();
    wp = 1'b0;
    rd_chk(0, 1);
    $display("Test protect done");
    nrst = 1'b0;
    cmd(7'h00, 1'b1, ack);
    chk_bit(ack, 1'b0);
    tws_master_inst.bus_stop();
    nrst = 1'b1;
    repeat (10) @(negedge clk);
    rd_chk(0, 1);
    $display("Test reset done");
    print_verdict();
  end
endmodule : tws_top_tb_top
